// *** logic/spapm_top.sv ***
// Purpose: Port A pin multiplexer for channel three, control port and DMA handshake
// Assumes: 25 MHz clk; pins arrive asynchronously and are synchronised
// Notes: Output enables are active low on the pins
// Operation
// - Control port enable hands three modem lines to control port, else channel three.
// - Each port A pin individually selects general I/O or dedicated function.
// - Channel three multiplexed mode drives its rate generator onto its transmit clock pin.
// - Channel two multiplexed drives tx clock pin; direct mode drives dedicated output.
// - Pin twelve is data bit twelve or channel three rate clock in direct mode.
// - Direct mode may also drive rate outputs on receive and transmit clock pins.
// - Control port rx shares clear-to-send pin, tx shares request-to-send pin.
// - Shared clock pin outputs control port clock or is carrier detect input.
// - Each DMA handshake pin may be general I/O while DMA keeps running.
// - Memory-to-memory DMA lets all three handshake pins be general I/O.
// - Clock invert zero shifts transmit on rising, samples receive on falling.
// - Clock invert one shifts transmit on falling, samples receive on rising.
//
// The address map and the plain strobed port were left to the implementer.
`default_nettype none
`include "spapm_defs.svh"
module spapm_top
   import spapm_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [`SPAPM_ADDR_W-1:0] reg_addr,
   input wire logic [`SPAPM_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [`SPAPM_DATA_W-1:0] reg_rdata,
   input wire logic [`SPAPM_PA_W-1:0] pa_in,
   output spapm_pins_t pa_pins,
   input wire logic ch3_modem_rxd_pin,
   output logic ch3_modem_txd_pin,
   input wire logic shared_clk_in,
   output logic shared_clk_out,
   output logic shared_clk_oe_n,
   input wire logic [`SPAPM_PA_W-1:0] ded_out,
   input wire logic [`SPAPM_PA_W-1:0] ded_oe,
   output logic [`SPAPM_PA_W-1:0] ded_in,
   input wire logic ch2_rate_gen_out,
   input wire logic ch3_rate_gen_out,
   output logic ch2_rate_gen_pin,
   input wire logic ch3_rts,
   output spapm_modem_t ch3_modem,
   input wire logic control_port_tx_data,
   output logic control_port_rx_data,
   input wire logic control_port_clock,
   output logic cp_tx_shift_en,
   output logic cp_rx_sample_en,
   output logic cp_clock_invert,
   output logic control_port_en
);
   logic [`SPAPM_DATA_W-1:0] pa_func_q;
   logic [`SPAPM_DATA_W-1:0] pa_dir_q;
   logic [`SPAPM_DATA_W-1:0] pa_dat_q;
   logic [`SPAPM_DATA_W-1:0] control_port_mode_reg_q;
   logic [`SPAPM_DATA_W-1:0] ch2_clock_config_q;
   logic [`SPAPM_DATA_W-1:0] ch3_clock_config_q;
   logic [`SPAPM_DATA_W-1:0] mux_mode_q;
   logic [`SPAPM_DATA_W-1:0] reg_rdata_q;
   logic [`SPAPM_PA_W:0] sync_q;
   logic [`SPAPM_PA_W-1:0] pa_s;
   logic cd_s;
   logic cp_clk_q;
   logic [`SPAPM_PA_W-1:0] pin_o;
   logic [`SPAPM_PA_W-1:0] pin_oe_n;
   logic ch2_mux;
   logic ch3_mux;
   logic cp_en;
   logic clk_inv;

   function automatic logic addr_hit(input logic [`SPAPM_ADDR_W-1:0] a, input logic [`SPAPM_ADDR_W-1:0] off);
      addr_hit = (a == off);
   endfunction

   spapm_sync u_sync
   (
      .clk(clk),
      .rst_n(rst_n),
      .d({shared_clk_in, pa_in}),
      .q(sync_q)
   );
   assign pa_s = sync_q[`SPAPM_PA_W-1:0];
   assign cd_s = sync_q[`SPAPM_PA_W];

   assign cp_en = control_port_mode_reg_q[`SPAPM_BIT_EN];
   assign clk_inv = control_port_mode_reg_q[`SPAPM_BIT_INV];
   assign ch2_mux = mux_mode_q[`SPAPM_BIT_CH2MUX];
   assign ch3_mux = mux_mode_q[`SPAPM_BIT_CH3MUX];

   // Pin function select: 1 = dedicated function
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         pa_func_q <= `SPAPM_RST_16;
      else if (reg_wr && addr_hit(reg_addr, `SPAPM_OFF_PACNT))
         pa_func_q <= reg_wdata;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         pa_dir_q <= `SPAPM_RST_16;
      else if (reg_wr && addr_hit(reg_addr, `SPAPM_OFF_PADDR))
         pa_dir_q <= reg_wdata;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         pa_dat_q <= `SPAPM_RST_16;
      else if (reg_wr && addr_hit(reg_addr, `SPAPM_OFF_PADAT))
         pa_dat_q <= reg_wdata;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         control_port_mode_reg_q <= `SPAPM_RST_16;
      else if (reg_wr && addr_hit(reg_addr, `SPAPM_OFF_CPMODE))
         control_port_mode_reg_q <= reg_wdata;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         ch2_clock_config_q <= `SPAPM_RST_16;
      else if (reg_wr && addr_hit(reg_addr, `SPAPM_OFF_CLKCFG2))
         ch2_clock_config_q <= reg_wdata;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         ch3_clock_config_q <= `SPAPM_RST_16;
      else if (reg_wr && addr_hit(reg_addr, `SPAPM_OFF_CLKCFG3))
         ch3_clock_config_q <= reg_wdata;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         mux_mode_q <= `SPAPM_RST_16;
      else if (reg_wr && addr_hit(reg_addr, `SPAPM_OFF_MODE))
         mux_mode_q <= reg_wdata;
   end

   // Data reads return pin level on inputs, latch on outputs
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         reg_rdata_q <= `SPAPM_RST_16;
      else if (reg_rd)
      begin
         unique case (reg_addr)
            `SPAPM_OFF_PACNT: reg_rdata_q <= pa_func_q;
            `SPAPM_OFF_PADDR: reg_rdata_q <= pa_dir_q;
            `SPAPM_OFF_PADAT: reg_rdata_q <= (pa_dat_q & pa_dir_q) | (pa_s & ~pa_dir_q);
            `SPAPM_OFF_CPMODE: reg_rdata_q <= control_port_mode_reg_q;
            `SPAPM_OFF_CLKCFG2: reg_rdata_q <= ch2_clock_config_q;
            `SPAPM_OFF_CLKCFG3: reg_rdata_q <= ch3_clock_config_q;
            `SPAPM_OFF_MODE: reg_rdata_q <= mux_mode_q;
            default: reg_rdata_q <= `SPAPM_RST_16;
         endcase
      end
      else
         reg_rdata_q <= `SPAPM_RST_16;
   end
   assign reg_rdata = reg_rdata_q;

   // Per-pin output mux; rate clocks override the dedicated source
   always_comb
   begin
      pin_o = '0;
      pin_oe_n = '1;
      for (int i = 0; i < `SPAPM_PA_W; i++)
      begin
         if (pa_func_q[i])
         begin
            pin_o[i] = ded_out[i];
            pin_oe_n[i] = ~ded_oe[i];
         end
         else
         begin
            pin_o[i] = pa_dat_q[i];
            pin_oe_n[i] = ~pa_dir_q[i];
         end
      end
      if (pa_func_q[`SPAPM_PA_TXCLK2] && ch2_mux)
      begin
         pin_o[`SPAPM_PA_TXCLK2] = ch2_rate_gen_out;
         pin_oe_n[`SPAPM_PA_TXCLK2] = 1'h0;
      end
      if (pa_func_q[`SPAPM_PA_TXCLK3] && ch3_mux)
      begin
         pin_o[`SPAPM_PA_TXCLK3] = ch3_rate_gen_out;
         pin_oe_n[`SPAPM_PA_TXCLK3] = 1'h0;
      end
      if (!ch2_mux && pa_func_q[`SPAPM_PA_TXCLK2] && !ch2_clock_config_q[`SPAPM_BIT_TCS])
      begin
         pin_o[`SPAPM_PA_TXCLK2] = ch2_rate_gen_out;
         pin_oe_n[`SPAPM_PA_TXCLK2] = 1'h0;
      end
      if (!ch2_mux && pa_func_q[`SPAPM_PA_RCLK2] && !ch2_clock_config_q[`SPAPM_BIT_RCS])
      begin
         pin_o[`SPAPM_PA_RCLK2] = ch2_rate_gen_out;
         pin_oe_n[`SPAPM_PA_RCLK2] = 1'h0;
      end
      if (!ch3_mux && pa_func_q[`SPAPM_PA_TXCLK3] && !ch3_clock_config_q[`SPAPM_BIT_TCS])
      begin
         pin_o[`SPAPM_PA_TXCLK3] = ch3_rate_gen_out;
         pin_oe_n[`SPAPM_PA_TXCLK3] = 1'h0;
      end
      if (!ch3_mux && pa_func_q[`SPAPM_PA_RCLK3] && !ch3_clock_config_q[`SPAPM_BIT_RCS])
      begin
         pin_o[`SPAPM_PA_RCLK3] = ch3_rate_gen_out;
         pin_oe_n[`SPAPM_PA_RCLK3] = 1'h0;
      end
      if (pa_func_q[`SPAPM_PA_RATE2] && !ch2_mux)
      begin
         pin_o[`SPAPM_PA_RATE2] = ch2_rate_gen_out;
         pin_oe_n[`SPAPM_PA_RATE2] = 1'h0;
      end
      // Pin twelve clock only in direct mode; multiplexed mode falls back to port data
      if (pa_func_q[`SPAPM_PA_BIT12])
      begin
         pin_o[`SPAPM_PA_BIT12] = ch3_mux ? pa_dat_q[`SPAPM_PA_BIT12] : ch3_rate_gen_out;
         pin_oe_n[`SPAPM_PA_BIT12] = ch3_mux ? ~pa_dir_q[`SPAPM_PA_BIT12] : 1'h0;
      end
   end

   assign pa_pins.i = pa_s;
   assign pa_pins.o = pin_o;
   assign pa_pins.oe_n = pin_oe_n;
   // DMA pins in general mode just read the port; the DMA engine sees idle inputs
   assign ded_in = pa_s & pa_func_q;
   assign ch2_rate_gen_pin = ch2_mux ? 1'b0 : ch2_rate_gen_out;

   // Modem lines: control port owns them when enabled
   logic rxd_s_meta_q;
   logic rxd_s_q;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rxd_s_meta_q <= 1'b0;
         rxd_s_q <= 1'b0;
      end
      else
      begin
         rxd_s_meta_q <= ch3_modem_rxd_pin;
         rxd_s_q <= rxd_s_meta_q;
      end
   end

   assign control_port_rx_data = cp_en ? rxd_s_q : 1'b0;
   assign ch3_modem.cts = cp_en ? 1'b0 : rxd_s_q;
   assign ch3_modem.rts = cp_en ? control_port_tx_data : ch3_rts;
   assign ch3_modem.cd = cp_en ? 1'b0 : cd_s;
   assign ch3_modem_txd_pin = cp_en ? control_port_tx_data : ch3_rts;
   assign shared_clk_out = cp_en ? control_port_clock : 1'b0;
   assign shared_clk_oe_n = ~cp_en;

   // Edge strobes for the control port shifter, chosen by clock invert
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         cp_clk_q <= 1'b0;
      else
         cp_clk_q <= control_port_clock;
   end
   logic rise;
   logic fall;
   assign rise = control_port_clock & ~cp_clk_q;
   assign fall = ~control_port_clock & cp_clk_q;
   assign cp_tx_shift_en = cp_en & (clk_inv ? fall : rise);
   assign cp_rx_sample_en = cp_en & (clk_inv ? rise : fall);
   assign cp_clock_invert = clk_inv;
   assign control_port_en = cp_en;
endmodule
`default_nettype wire

// *** logic/spapm_defs.svh ***
// Purpose: Constants for the port A pin multiplexer
// Assumes: Included by bare name
// Notes: Register offsets are byte addresses on the plain register port
`ifndef SPAPM_DEFS_SVH
`define SPAPM_DEFS_SVH
`define SPAPM_ADDR_W 4
`define SPAPM_DATA_W 16
`define SPAPM_PA_W 16
`define SPAPM_OFF_PACNT 4'h0
`define SPAPM_OFF_PADDR 4'h2
`define SPAPM_OFF_PADAT 4'h4
`define SPAPM_OFF_CPMODE 4'h6
`define SPAPM_OFF_CLKCFG2 4'h8
`define SPAPM_OFF_CLKCFG3 4'ha
`define SPAPM_OFF_MODE 4'hc
`define SPAPM_RST_16 16'h0000
`define SPAPM_BIT_EN 0
`define SPAPM_BIT_INV 1
`define SPAPM_BIT_TCS 13
`define SPAPM_BIT_RCS 12
`define SPAPM_BIT_CH2MUX 0
`define SPAPM_BIT_CH3MUX 1
`define SPAPM_BIT_SCPCLK_GEN 2
`define SPAPM_PA_RCLK2 2
`define SPAPM_PA_TXCLK2 3
`define SPAPM_PA_RATE2 7
`define SPAPM_PA_RCLK3 10
`define SPAPM_PA_TXCLK3 11
`define SPAPM_PA_BIT12 12
`define SPAPM_PA_DMA0 13
`define SPAPM_DMA_N 3
`endif

// *** logic/spapm_pkg.sv ***
// Purpose: Types for the port A pin multiplexer
// Assumes: spapm_defs.svh is on the include path
// Notes: Only types live here
`default_nettype none
`include "spapm_defs.svh"
package spapm_pkg;
   typedef struct packed
   {
      logic [`SPAPM_PA_W-1:0] i;
      logic [`SPAPM_PA_W-1:0] o;
      logic [`SPAPM_PA_W-1:0] oe_n;
   } spapm_pins_t;
   typedef struct packed
   {
      logic cts;
      logic rts;
      logic cd;
   } spapm_modem_t;
endpackage
`default_nettype wire

// *** logic/spapm_sync.sv ***
// Purpose: Two-flop synchroniser bank for pin inputs
// Assumes: Single clock domain
// Notes: First stage is read only by the second
`default_nettype none
`include "spapm_defs.svh"
module spapm_sync
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [`SPAPM_PA_W:0] d,
   output logic [`SPAPM_PA_W:0] q
);
   logic [`SPAPM_PA_W:0] meta_q;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_q <= '0;
         q <= '0;
      end
      else
      begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule
`default_nettype wire

// *** testbench/spapm_properties.sv ***
// Purpose: Port-level properties of the port A multiplexer
// Assumes: Shadow copies of the registers track the same writes
// Notes: Edge windows allow three cycles of detection latency
`default_nettype none
`include "spapm_defs.svh"
module spapm_props
   import spapm_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [`SPAPM_ADDR_W-1:0] reg_addr,
   input wire logic [`SPAPM_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire spapm_pins_t pa_pins,
   input wire logic ch3_rate_gen_out,
   input wire logic ch2_rate_gen_pin,
   input wire logic ch3_rts,
   input wire spapm_modem_t ch3_modem,
   input wire logic ch3_modem_txd_pin,
   input wire logic shared_clk_oe_n,
   input wire logic control_port_tx_data,
   input wire logic control_port_clock,
   input wire logic cp_tx_shift_en,
   input wire logic cp_rx_sample_en,
   input wire logic cp_clock_invert,
   input wire logic control_port_en
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] sel_q, dir_q, dat_q;
   logic [1:0] mux_q;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         {sel_q, dir_q, dat_q, mux_q} <= '0;
      else if (reg_wr)
      begin
         if (reg_addr == `SPAPM_OFF_PACNT) sel_q <= reg_wdata;
         if (reg_addr == `SPAPM_OFF_PADDR) dir_q <= reg_wdata;
         if (reg_addr == `SPAPM_OFF_PADAT) dat_q <= reg_wdata;
         if (reg_addr == `SPAPM_OFF_MODE) mux_q <= reg_wdata[1:0];
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   chk_gpio_dir: assert property ((pa_pins.oe_n | sel_q) == (~dir_q | sel_q))
      else $error("gpio direction wrong");
   chk_gpio_data: assert property ((pa_pins.o & dir_q & ~sel_q) == (dat_q & dir_q & ~sel_q))
      else $error("gpio data wrong");
   chk_modem_own: assert property (control_port_en && $past(control_port_en) |-> !ch3_modem.cts && !ch3_modem.cd)
      else $error("modem lines not handed over");
   chk_tx_share: assert property (ch3_modem_txd_pin == (control_port_en ? control_port_tx_data : ch3_rts))
      else $error("shared tx pin wrong source");
   chk_clk_owner: assert property (shared_clk_oe_n == !control_port_en)
      else $error("clock pin direction wrong");
   chk_ch2_mux: assert property (mux_q[`SPAPM_BIT_CH2MUX] |-> !ch2_rate_gen_pin)
      else $error("ch2 rate pin active when multiplexed");
   chk_pin12_rate: assert property (sel_q[12] && !mux_q[1] |-> pa_pins.o[12] == ch3_rate_gen_out && !pa_pins.oe_n[12])
      else $error("pin twelve rate clock wrong");
   chk_tx_rise: assert property ($rose(control_port_clock) && control_port_en && !cp_clock_invert |-> ##[0:3] cp_tx_shift_en)
      else $error("no tx shift on rising edge");
   chk_rx_fall: assert property ($fell(control_port_clock) && control_port_en && !cp_clock_invert |-> ##[0:3] cp_rx_sample_en)
      else $error("no rx sample on falling edge");
   chk_tx_fall: assert property ($fell(control_port_clock) && control_port_en && cp_clock_invert |-> ##[0:3] cp_tx_shift_en)
      else $error("no tx shift on falling edge");
   chk_rx_rise: assert property ($rose(control_port_clock) && control_port_en && cp_clock_invert |-> ##[0:3] cp_rx_sample_en)
      else $error("no rx sample on rising edge");
   cov_inv_shift: cover property (control_port_en && cp_clock_invert && cp_tx_shift_en);
   cov_mux_ch3: cover property (mux_q[1] && sel_q[11]);
   cov_pin12: cover property (sel_q[12] && !mux_q[1]);
endmodule
bind spapm_top spapm_props u_props (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .pa_pins, .ch3_rate_gen_out,
   .ch2_rate_gen_pin, .ch3_rts, .ch3_modem, .ch3_modem_txd_pin, .shared_clk_oe_n, .control_port_tx_data,
   .control_port_clock, .cp_tx_shift_en, .cp_rx_sample_en, .cp_clock_invert, .control_port_en);
`default_nettype wire

// *** testbench/spapm_far_end.sv ***
// Purpose: Pins, modem and serial peripheral beyond port A
// Assumes: Released pins are held by external drivers given in ext
// Notes: Peripheral shifts on the edge the device does not sample
`default_nettype none
module spapm_far_end
   import spapm_pkg::*;
(
   input wire spapm_pins_t pa_pins,
   input wire logic [15:0] ext,
   input wire logic shared_clk_out,
   input wire logic shared_clk_oe_n,
   input wire logic cp_clock_invert,
   input wire logic cts_lvl,
   input wire logic cd_lvl,
   output logic [15:0] pa_in,
   output logic ch3_modem_rxd_pin,
   output logic shared_clk_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic sp_q = 1'h0;
   assign pa_in = (pa_pins.o & ~pa_pins.oe_n) | (ext & pa_pins.oe_n);
   assign shared_clk_in = shared_clk_oe_n ? cd_lvl : shared_clk_out;
   assign ch3_modem_rxd_pin = shared_clk_oe_n ? cts_lvl : sp_q;
   always @(shared_clk_out)
      if (!shared_clk_oe_n && (shared_clk_out ^ cp_clock_invert)) sp_q <= ~sp_q;
endmodule
`default_nettype wire

// *** testbench/spapm_top_bench.sv ***
// Purpose: Self-checking bench for the port A multiplexer
// Assumes: Strobes one cycle, checks taken at the falling edge
// Notes: Register tasks start at a rising edge
`default_nettype none
`include "spapm_defs.svh"
module spapm_top_bench
   import spapm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, ch2_rate_gen_out = 0, ch3_rate_gen_out = 0, ch3_rts = 0;
   logic control_port_tx_data = 0, control_port_clock = 0, cts_lvl = 0, cd_lvl = 0;
   logic [3:0] reg_addr = 0;
   logic [15:0] reg_wdata = 0, ext = 0, ded_out = 0, ded_oe = 0, reg_rdata, pa_in, ded_in;
   logic ch3_modem_rxd_pin, ch3_modem_txd_pin, shared_clk_in, shared_clk_out, shared_clk_oe_n, ch2_rate_gen_pin;
   logic control_port_rx_data, cp_tx_shift_en, cp_rx_sample_en, cp_clock_invert, control_port_en;
   spapm_pins_t pa_pins;
   spapm_modem_t ch3_modem;
   int err_count = 0, tests_run = 0;
   spapm_top DUT (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pa_in, .pa_pins,
      .ch3_modem_rxd_pin, .ch3_modem_txd_pin, .shared_clk_in, .shared_clk_out, .shared_clk_oe_n, .ded_out,
      .ded_oe, .ded_in, .ch2_rate_gen_out, .ch3_rate_gen_out, .ch2_rate_gen_pin, .ch3_rts, .ch3_modem,
      .control_port_tx_data, .control_port_rx_data, .control_port_clock, .cp_tx_shift_en, .cp_rx_sample_en,
      .cp_clock_invert, .control_port_en);
   spapm_far_end u_far (.pa_pins, .ext, .shared_clk_out, .shared_clk_oe_n, .cp_clock_invert, .cts_lvl,
      .cd_lvl, .pa_in, .ch3_modem_rxd_pin, .shared_clk_in);
   initial forever #20 clk = ~clk;
   task automatic check(input logic ok, input string m);
      tests_run++;
      if (ok !== 1'h1)
      begin
         err_count++;
         $display("mismatch %0t %s", $time, m);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_rd <= 1'h0;
      reg_wr <= 1'h1;
   endtask
   task automatic idle;
      @(posedge clk);
      reg_wr <= 1'h0;
      reg_rd <= 1'h0;
      repeat (3) @(negedge clk);
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_wr <= 1'h0;
      reg_rd <= 1'h1;
      @(posedge clk);
      reg_rd <= 1'h0;
      @(negedge clk);
      check(reg_rdata === e, "read");
   endtask
   task automatic t_basic;
      check(pa_pins.oe_n === 16'hffff && shared_clk_oe_n === 1'h1, "reset pins");
      for (int a = 0; a < 16; a += 2)
         rd(a[3:0], 16'h0000);
      wr(`SPAPM_OFF_PADDR, 16'h00a5);
      ext <= 16'h5a5a;
      wr(`SPAPM_OFF_PADAT, 16'h0f0f);
      wr(4'he, 16'hffff);
      idle();
      check(pa_pins.oe_n === 16'hff5a && (pa_pins.o & 16'h00a5) === 16'h0005, "gpio out");
      check(pa_pins.i === 16'h5a5f, "gpio in");
      rd(`SPAPM_OFF_PACNT, 16'h0000);
      rd(`SPAPM_OFF_PADDR, 16'h00a5);
   endtask
   task automatic t_dma;
      wr(`SPAPM_OFF_PACNT, 16'h2001);
      ded_out <= 16'h0001;
      ded_oe <= 16'h0001;
      ext <= 16'h2000;
      wr(`SPAPM_OFF_PADDR, 16'hc000);
      wr(`SPAPM_OFF_PADAT, 16'h4000);
      idle();
      check(pa_pins.o[0] === 1'h1 && pa_pins.oe_n[0] === 1'h0, "dedicated pin");
      check(pa_pins.oe_n[15:13] === 3'h1 && pa_pins.o[15:14] === 2'h1, "dma gpio");
      check(ded_in[14:13] === 2'h1, "dma handshake in");
      wr(`SPAPM_OFF_PACNT, 16'h0000);
      wr(`SPAPM_OFF_PADDR, 16'he000);
      idle();
      check(pa_pins.oe_n[15:13] === 3'h0 && ded_in[15:13] === 3'h0, "all dma gpio");
   endtask
   task automatic t_rate;
      wr(`SPAPM_OFF_PACNT, 16'h1c8c);
      for (int m = 0; m < 4; m++)
      begin
         wr(`SPAPM_OFF_MODE, m[1] ? 16'h0000 : 16'h0003);
         ch3_rate_gen_out <= m[0];
         ch2_rate_gen_out <= m[0];
         idle();
         check(pa_pins.o[11] === m[0] && pa_pins.oe_n[11] === 1'h0, "ch3 tx clock");
         check(pa_pins.o[3] === m[0] && pa_pins.oe_n[3] === 1'h0, "ch2 tx clock");
         check(ch2_rate_gen_pin === (m[1] & m[0]), "ch2 rate pin");
         check(pa_pins.oe_n[12] === !m[1] && (!m[1] || pa_pins.o[12] === m[0]), "pin twelve");
         check(pa_pins.oe_n[2] === !m[1] && (!m[1] || pa_pins.o[2] === m[0]), "ch2 rx clock");
         check(pa_pins.oe_n[10] === !m[1] && (!m[1] || pa_pins.o[10] === m[0]), "ch3 rx clock");
         check(pa_pins.oe_n[7] === !m[1] && (!m[1] || pa_pins.o[7] === m[0]), "ch2 rate on port");
      end
      wr(`SPAPM_OFF_CLKCFG3, 16'h2000);
      idle();
      check(pa_pins.oe_n[11] === 1'h1 && pa_pins.oe_n[10] === 1'h0, "external tx clock");
   endtask
   task automatic t_modem;
      wr(`SPAPM_OFF_CPMODE, 16'h0000);
      cts_lvl <= 1'h1;
      cd_lvl <= 1'h1;
      ch3_rts <= 1'h1;
      idle();
      check(ch3_modem.cts === 1'h1 && ch3_modem.cd === 1'h1 && ch3_modem.rts === 1'h1, "modem to channel");
      check(ch3_modem_txd_pin === 1'h1 && shared_clk_oe_n === 1'h1 && shared_clk_out === 1'h0, "channel owns");
      wr(`SPAPM_OFF_CPMODE, 16'h0001);
      ch3_rts <= 1'h0;
      control_port_tx_data <= 1'h1;
      idle();
      check(ch3_modem.cts === 1'h0 && ch3_modem_txd_pin === 1'h1, "control port owns");
      check(shared_clk_oe_n === 1'h0 && control_port_rx_data === ch3_modem_rxd_pin, "port pins");
      check(shared_clk_out === control_port_clock, "port clock out");
   endtask
   task automatic t_edges;
      logic tx;
      logic rx;
      for (int c = 0; c < 2; c++)
      begin
         wr(`SPAPM_OFF_CPMODE, {14'h0000, c[0], 1'h1});
         idle();
         for (int k = 0; k < 4; k++)
         begin
            @(posedge clk);
            control_port_clock <= !control_port_clock;
            tx = 1'h0;
            rx = 1'h0;
            repeat (4)
            begin
               @(negedge clk);
               tx |= cp_tx_shift_en;
               rx |= cp_rx_sample_en;
            end
            check(tx === (control_port_clock ^ c[0]) && rx === !tx, "edge");
            check(control_port_rx_data === ch3_modem_rxd_pin, "rx data");
            check(shared_clk_out === control_port_clock && cp_clock_invert === c[0], "clock out");
         end
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      #100us;
      err_count++;
      end_of_test();
   end
   initial
   begin
      repeat (8) @(posedge clk);
      rst_n <= 1'h1;
      t_basic();
      t_dma();
      t_rate();
      t_modem();
      t_edges();
      end_of_test();
   end
endmodule
`default_nettype wire
